// File: rtl/chan_out_defs.vh
`ifndef CHAN_OUT_DEFS_VH
`define CHAN_OUT_DEFS_VH
// ***********************************************
// register map
// ***********************************************
`define ADDR_ENABLE_POLARITY 4'h0
`define ADDR_RUN_CONTROL 4'h4
`define ADDR_IDLE_LEVELS 4'h8
`define ADDR_DEADTIME 4'hC
`define RESET_ENABLE_POLARITY 32'h00000000
`define ENABLE_POLARITY_MASK 32'h00003FFF
`define RUN_CONTROL_MASK 32'h00000007
`define IDLE_LEVELS_MASK 32'h0000003F
`define DEADTIME_MASK 32'h000000FF
// ***********************************************
// field positions
// ***********************************************
`define FLD_MAIN_EN 0
`define FLD_MAIN_POL 1
`define FLD_COMP_EN 2
`define FLD_COMP_POL 3
`define FLD_CH4_EN 12
`define FLD_CH4_POL 13
`define FLD_MOE 0
`define FLD_IDLE_OFFSTATE_SELECT 1
`define FLD_RUN_OFFSTATE_SELECT 2
`define DIR_OUTPUT 2'h0
`define DEADTIME_WIDTH 8
`endif

// File: rtl/pair_drive.v
`timescale 1ns/1ps
`default_nettype none
// ***********************************************
// one complementary pair, output decision
// ***********************************************
module pair_drive #(
    parameter DTW = 8
) (
    input wire mclk,
    input wire rst,
    input wire ref_in,
    input wire main_en,
    input wire main_pol,
    input wire comp_en,
    input wire comp_pol,
    input wire main_idle,
    input wire comp_idle,
    input wire main_output_enable,
    input wire idle_offstate_select,
    input wire run_offstate_select,
    input wire [DTW-1:0] dead_cycles,
    output reg main_out,
    output reg main_oe,
    output reg comp_out,
    output reg comp_oe
);
    reg [DTW-1:0] dt_cnt_r;
    reg ref_d_r;
    reg moe_d_r;
    reg idle_done_r;
    wire dt_busy = (dt_cnt_r != {DTW{1'b0}});
    wire ref_chg = (ref_in != ref_d_r);
    reg main_out_nxt;
    reg main_oe_nxt;
    reg comp_out_nxt;
    reg comp_oe_nxt;

    // ***********************************************
    // dead-time counter, restarts on edges and on moe drop
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            dt_cnt_r <= {DTW{1'b0}};
            ref_d_r <= 1'b0;
            moe_d_r <= 1'b0;
            idle_done_r <= 1'b0;
        end else begin
            ref_d_r <= ref_in;
            moe_d_r <= main_output_enable;
            if ((ref_chg && main_output_enable) || (moe_d_r && !main_output_enable)) begin
                dt_cnt_r <= dead_cycles;
            end else if (dt_busy) begin
                dt_cnt_r <= dt_cnt_r - {{(DTW-1){1'b0}}, 1'b1};
            end
            if (main_output_enable) begin
                idle_done_r <= 1'b0;
            end else if (!dt_busy && !(moe_d_r && !main_output_enable)) begin
                idle_done_r <= 1'b1;
            end
        end
    end

    // ***********************************************
    // output table
    // ***********************************************
    always @* begin
        main_out_nxt = 1'b0;
        main_oe_nxt = 1'b0;
        comp_out_nxt = 1'b0;
        comp_oe_nxt = 1'b0;
        if (main_output_enable) begin
            if (main_en && comp_en) begin
                main_out_nxt = (ref_d_r && !dt_busy) ^ main_pol;
                comp_out_nxt = (!ref_d_r && !dt_busy) ^ comp_pol;
                main_oe_nxt = 1'b1;
                comp_oe_nxt = 1'b1;
            end else if (main_en) begin
                main_out_nxt = ref_in ^ main_pol;
                main_oe_nxt = 1'b1;
                comp_out_nxt = run_offstate_select ? comp_pol : 1'b0;
                comp_oe_nxt = run_offstate_select;
            end else if (comp_en) begin
                comp_out_nxt = ref_in ^ comp_pol;
                comp_oe_nxt = 1'b1;
                main_out_nxt = run_offstate_select ? main_pol : 1'b0;
                main_oe_nxt = run_offstate_select;
            end else begin
                main_out_nxt = run_offstate_select ? main_pol : 1'b0;
                comp_out_nxt = run_offstate_select ? comp_pol : 1'b0;
            end
        end else if (idle_done_r) begin
            main_out_nxt = main_idle;
            comp_out_nxt = comp_idle;
            main_oe_nxt = idle_offstate_select;
            comp_oe_nxt = idle_offstate_select;
        end else begin
            main_out_nxt = main_pol;
            comp_out_nxt = comp_pol;
            main_oe_nxt = idle_offstate_select;
            comp_oe_nxt = idle_offstate_select;
        end
    end

    // ***********************************************
    // registered pins, registered again one level up
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            main_out <= 1'b0;
            main_oe <= 1'b0;
            comp_out <= 1'b0;
            comp_oe <= 1'b0;
        end else begin
            main_out <= main_out_nxt;
            main_oe <= main_oe_nxt;
            comp_out <= comp_out_nxt;
            comp_oe <= comp_oe_nxt;
        end
    end
endmodule
`default_nettype wire

// File: rtl/timer_channel_output_control.v
// Summary of operation
// - output polarity 1 inverts main reference
// - input polarity picks rising or falling edge
// - main polarity locked at protect level 2-3
// - comp polarity locked at level 2-3 output
// - comp polarity 1 makes comp active low
// - main enable passes reference to pin
// - main enable gates capture in input mode
// - comp enable passes reference out, inverted only with main enabled
// - four bits per channel, ch4 two bits
// - bits 31:14 reserved, read zero
// - moe on, run off, none enabled: undriven
// - single enabled output: reference xor polarity
// - both enabled: complementary with dead-time
// - run off-state keeps disabled output inactive
// - run off-state, none enabled: undriven polarity
// - moe off, idle select 0: undriven polarity
// - moe off, idle select 1: driven polarity
// - after moe drop, dead-time then idle levels (ch4 here goes straight to its polarity, no dead-time or idle level)
// - direction 00 means output
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "chan_out_defs.vh"
module timer_channel_output_control #(
    parameter DTW = `DEADTIME_WIDTH,
    parameter CNTW = 16
) (
    input wire mclk,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [1:0] protect_level,
    input wire [7:0] direction_select,
    input wire [3:0] compare_reference,
    input wire [3:0] capture_input,
    input wire [CNTW-1:0] counter_value,
    output reg [3:0] main_output,
    output reg [3:0] main_drive_enable,
    output reg [2:0] comp_output,
    output reg [2:0] comp_drive_enable,
    output reg [3:0] capture_trigger,
    output reg [4*CNTW-1:0] capture_value
);
    reg [13:0] enpol_r;
    reg [2:0] runctl_r;
    reg [5:0] idle_r;
    reg [DTW-1:0] dead_r;
    reg [3:0] cap_d_r;
    reg ack_r;
    reg [31:0] wmask;
    wire main_output_enable = runctl_r[`FLD_MOE];
    wire idle_offstate_select = runctl_r[`FLD_IDLE_OFFSTATE_SELECT];
    wire run_offstate_select = runctl_r[`FLD_RUN_OFFSTATE_SELECT];
    wire locked = protect_level[1];
    wire wr_go = avs_write && ack_r;
    wire [31:0] enpol_rst = `RESET_ENABLE_POLARITY;
    wire [2:0] p_mo;
    wire [2:0] p_moe;
    wire [2:0] p_co;
    wire [2:0] p_coe;
    reg [13:0] enpol_nxt;
    integer i;

    // ***********************************************
    // byte-lane mask and protected write of polarities
    // ***********************************************
    always @* begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        enpol_nxt = (enpol_r & ~wmask[13:0]) | (avs_writedata[13:0] & wmask[13:0]);
        for (i = 0; i < 3; i = i + 1) begin
            if (locked) begin
                enpol_nxt[4*i+`FLD_MAIN_POL] = enpol_r[4*i+`FLD_MAIN_POL];
                if (direction_select[2*i +: 2] == `DIR_OUTPUT) begin
                    enpol_nxt[4*i+`FLD_COMP_POL] = enpol_r[4*i+`FLD_COMP_POL];
                end
            end
        end
        if (locked) begin
            enpol_nxt[`FLD_CH4_POL] = enpol_r[`FLD_CH4_POL];
        end
    end

    // ***********************************************
    // avalon slave, one wait cycle per access
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            enpol_r <= enpol_rst[13:0];
            runctl_r <= 3'h0;
            idle_r <= 6'h00;
            dead_r <= {DTW{1'b0}};
            ack_r <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (wr_go) begin
                case (avs_address)
                    `ADDR_ENABLE_POLARITY: enpol_r <= enpol_nxt;
                    `ADDR_RUN_CONTROL: runctl_r <= (runctl_r & ~wmask[2:0]) |
                        (avs_writedata[2:0] & wmask[2:0]);
                    `ADDR_IDLE_LEVELS: idle_r <= (idle_r & ~wmask[5:0]) |
                        (avs_writedata[5:0] & wmask[5:0]);
                    `ADDR_DEADTIME: dead_r <= (dead_r & ~wmask[DTW-1:0]) |
                        (avs_writedata[DTW-1:0] & wmask[DTW-1:0]);
                    default: ;
                endcase
            end
            if (avs_read && !ack_r) begin
                case (avs_address)
                    `ADDR_ENABLE_POLARITY: avs_readdata <= {18'h00000, enpol_r};
                    `ADDR_RUN_CONTROL: avs_readdata <= {29'h00000000, runctl_r};
                    `ADDR_IDLE_LEVELS: avs_readdata <= {26'h0000000, idle_r};
                    `ADDR_DEADTIME: avs_readdata <= {{(32-DTW){1'b0}}, dead_r};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r && avs_waitrequest);
        end
    end

    // ***********************************************
    // complementary pairs, channels 1 to 3
    // ***********************************************
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : pair
            pair_drive #(.DTW(DTW)) u_pair (
                .mclk(mclk),
                .rst(rst),
                .ref_in(compare_reference[g]),
                .main_en(enpol_r[4*g+`FLD_MAIN_EN]),
                .main_pol(enpol_r[4*g+`FLD_MAIN_POL]),
                .comp_en(enpol_r[4*g+`FLD_COMP_EN]),
                .comp_pol(enpol_r[4*g+`FLD_COMP_POL]),
                .main_idle(idle_r[2*g]),
                .comp_idle(idle_r[2*g+1]),
                .main_output_enable(main_output_enable),
                .idle_offstate_select(idle_offstate_select),
                .run_offstate_select(run_offstate_select),
                .dead_cycles(dead_r),
                .main_out(p_mo[g]),
                .main_oe(p_moe[g]),
                .comp_out(p_co[g]),
                .comp_oe(p_coe[g])
            );
        end
    endgenerate

    // ***********************************************
    // pins; input-mode channels stay undriven
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            main_output <= 4'h0;
            main_drive_enable <= 4'h0;
            comp_output <= 3'h0;
            comp_drive_enable <= 3'h0;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                main_output[i] <= p_mo[i];
                main_drive_enable[i] <= p_moe[i] && (direction_select[2*i +: 2] == `DIR_OUTPUT);
                comp_output[i] <= p_co[i];
                comp_drive_enable[i] <= p_coe[i] && (direction_select[2*i +: 2] == `DIR_OUTPUT);
            end
            if (direction_select[7:6] != `DIR_OUTPUT) begin
                main_output[3] <= 1'b0;
                main_drive_enable[3] <= 1'b0;
            end else if (!main_output_enable) begin
                main_output[3] <= enpol_r[`FLD_CH4_POL];
                main_drive_enable[3] <= idle_offstate_select;
            end else if (enpol_r[`FLD_CH4_EN]) begin
                main_output[3] <= compare_reference[3] ^ enpol_r[`FLD_CH4_POL];
                main_drive_enable[3] <= 1'b1;
            end else begin
                main_output[3] <= run_offstate_select ? enpol_r[`FLD_CH4_POL] : 1'b0;
                main_drive_enable[3] <= 1'b0;
            end
        end
    end

    // ***********************************************
    // capture edge selection and gating
    // ***********************************************
    always @(posedge mclk) begin
        if (rst) begin
            cap_d_r <= 4'h0;
            capture_trigger <= 4'h0;
            capture_value <= {(4*CNTW){1'b0}};
        end else begin
            cap_d_r <= capture_input;
            for (i = 0; i < 4; i = i + 1) begin
                capture_trigger[i] <= capture_input[i] ^ enpol_r[4*i+`FLD_MAIN_POL];
                if ((direction_select[2*i +: 2] != `DIR_OUTPUT) && enpol_r[4*i] &&
                    (enpol_r[4*i+`FLD_MAIN_POL] ? (cap_d_r[i] && !capture_input[i]) :
                     (!cap_d_r[i] && capture_input[i]))) begin
                    capture_value[i*CNTW +: CNTW] <= counter_value;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: test/chan_out_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "chan_out_defs.vh"
module chan_out_assertions #(
    parameter DTW = 8,
    parameter CNTW = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] protect_level,
    input wire logic [7:0] direction_select,
    input wire logic [3:0] compare_reference,
    input wire logic [3:0] capture_input,
    input wire logic [3:0] main_output,
    input wire logic [3:0] main_drive_enable,
    input wire logic [2:0] comp_output,
    input wire logic [2:0] comp_drive_enable,
    input wire logic [3:0] capture_trigger
);
    logic [13:0] shadow_r;
    logic [2:0] run_r;
    wire logic wr_ok = avs_write && !avs_waitrequest;
    wire logic o1 = direction_select[1:0] == `DIR_OUTPUT;
    wire logic [3:0] mpol = {shadow_r[13], shadow_r[9], shadow_r[5], shadow_r[1]};
    // ****************************************
    // register shadow
    // ****************************************
    always @(posedge mclk) begin
        if (rst) begin
            shadow_r <= 14'h0;
            run_r <= 3'h0;
        end else if (wr_ok && avs_address == `ADDR_RUN_CONTROL && avs_byteenable[0]) begin
            run_r <= avs_writedata[2:0];
        end else if (wr_ok && avs_address == `ADDR_ENABLE_POLARITY) begin
            for (int i = 0; i < 14; i++) begin
                if (avs_byteenable[i/8] && !(protect_level[1] && (i % 4 == 1 ||
                    (i % 4 == 3 && direction_select[2*(i/4)+:2] == `DIR_OUTPUT)))) begin
                    shadow_r[i] <= avs_writedata[i];
                end
            end
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_held(c);
        (c && $stable(shadow_r) && $stable(run_r) && $stable(compare_reference)) [*8];
    endsequence
    sequence s_pair_on;
        (o1 && run_r[0] && shadow_r[0] && shadow_r[2] && $stable(shadow_r)) [*4];
    endsequence
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_time: assert property (
        (avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest)
        else $error("access not answered");
    a_read_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
        else $error("read data moved without read");
    a_trig_pol: assert property (
        !$past(rst) |-> capture_trigger == ($past(capture_input) ^ $past(mpol)))
        else $error("trigger polarity wrong");
    a_input_quiet: assert property (
        s_held(!o1) |-> !main_drive_enable[0] && !comp_drive_enable[0])
        else $error("input channel drives pin");
    a_single_main: assert property (
        s_held(o1 && run_r[0] && !run_r[2] && shadow_r[0] && !shadow_r[2])
        |-> main_output[0] == (compare_reference[0] ^ shadow_r[1]) && main_drive_enable[0]
        && !comp_drive_enable[0] && !comp_output[0])
        else $error("single main output wrong");
    a_run_hold: assert property (
        s_held(o1 && run_r[0] && run_r[2] && shadow_r[0] && !shadow_r[2])
        |-> comp_drive_enable[0] && comp_output[0] == shadow_r[3])
        else $error("disabled output not held inactive");
    a_none_quiet: assert property (
        s_held(o1 && run_r[0] && !shadow_r[0] && !shadow_r[2])
        |-> !main_drive_enable[0] && !comp_drive_enable[0]
        && main_output[0] == (run_r[2] & shadow_r[1])
        && comp_output[0] == (run_r[2] & shadow_r[3]))
        else $error("unused pair not quiet");
    a_idle_drive: assert property (
        s_held(o1 && !run_r[0] && (shadow_r[0] || shadow_r[2]))
        |-> main_drive_enable[0] == run_r[1] && comp_drive_enable[0] == run_r[1])
        else $error("idle drive enable wrong");
    a_pair_excl: assert property (
        s_pair_on |-> !((main_output[0] ^ shadow_r[1]) && (comp_output[0] ^ shadow_r[3])))
        else $error("both pair outputs active");
endmodule
`default_nettype wire

// File: test/half_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// half bridge driven by one pair
// ****************************************
module half_bridge_model (
    input wire logic mclk,
    input wire logic high_gate,
    input wire logic high_oe,
    input wire logic low_gate,
    input wire logic low_oe,
    output var int shoot_count
);
    initial shoot_count = 0;
    // both switches on is shoot-through
    always @(posedge mclk) begin
        if (high_oe && low_oe && high_gate && low_gate) begin
            shoot_count <= shoot_count + 1;
        end
    end
endmodule
`default_nettype wire

// File: test/tb_timer_channel_output_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "chan_out_defs.vh"
module tb_timer_channel_output_control;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [1:0] protect_level = 2'h0;
    logic [7:0] direction_select = 8'h00;
    logic [3:0] compare_reference = 4'h0;
    logic [3:0] capture_input = 4'h0;
    logic [15:0] counter_value = 16'h0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest;
    wire logic [3:0] main_output, main_drive_enable, capture_trigger;
    wire logic [2:0] comp_output, comp_drive_enable;
    wire logic [63:0] capture_value;
    wire logic [3:0] pins1 = {main_output[0], main_drive_enable[0], comp_output[0],
        comp_drive_enable[0]};
    int mismatches = 0;
    int comparisons = 0;
    int shoot_count;
    int blank = 0;
    logic [31:0] rd;
    logic [19:0] r;
    // run, idle levels, enable nibble, reference, expected pins
    logic [19:0] rows [11] = '{20'h10000, 20'h1011C, 20'h10314, 20'h10C11, 20'h50105,
        20'h50A0A, 20'h1051D, 20'h10507, 20'h00310, 20'h20115, 20'h2150D};
    timer_channel_output_control u_timer_channel_output_control (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .protect_level, .direction_select,
        .compare_reference, .capture_input, .counter_value, .main_output,
        .main_drive_enable, .comp_output, .comp_drive_enable, .capture_trigger, .capture_value);
    half_bridge_model u_half_bridge_model (.mclk(mclk), .high_gate(main_output[0]),
        .high_oe(main_drive_enable[0]), .low_gate(comp_output[0]),
        .low_oe(comp_drive_enable[0]), .shoot_count(shoot_count));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) mismatches++;
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("reset value", rd, `RESET_ENABLE_POLARITY);
        chk("reset pins", {main_drive_enable, comp_drive_enable}, 32'h0);
        bus(1'b1, `ADDR_DEADTIME, 32'h3, 4'hF);
        for (int i = 0; i < 11; i++) begin
            r = rows[i];
            bus(1'b1, `ADDR_IDLE_LEVELS, {28'h0, r[15:12]}, 4'hF);
            bus(1'b1, `ADDR_ENABLE_POLARITY, {18'h0, r[9:8], {3{r[11:8]}}}, 4'hF);
            bus(1'b1, `ADDR_RUN_CONTROL, {28'h0, r[19:16]}, 4'hF);
            compare_reference <= {4{r[4]}};
            repeat (12) @(posedge mclk);
            chk("ch1 pins", pins1, r[3:0]);
            chk("ch4 pins", {main_output[3], main_drive_enable[3]}, r[16] ? (r[8] ? {r[4] ^ r[9], 1'b1} : {r[18] & r[9], 1'b0}) : {r[9], r[17]});
        end
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h555, 4'hF);
        bus(1'b1, `ADDR_RUN_CONTROL, 32'h1, 4'hF);
        repeat (12) @(posedge mclk);
        repeat (6) begin
            compare_reference <= ~compare_reference;
            repeat (10) begin
                @(posedge mclk);
                blank += (pins1 == 4'h5);
            end
        end
        chk("dead cycles", blank, 32'h12);
        chk("overlap", shoot_count, 32'h0);
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("reserved bits", rd, `ENABLE_POLARITY_MASK);
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h0, 4'h2);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("byte lane", rd, 32'h000000FF);
        bus(1'b1, 4'h2, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 4'h2, 32'h0, 4'hF);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'hFFFFFFFF, 4'hF);
        protect_level <= 2'h2;
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("lock output", rd, 32'h00002AAA);
        protect_level <= 2'h3;
        direction_select <= 8'h01;
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("lock input", rd, 32'h00002AA2);
        protect_level <= 2'h0;
        direction_select <= 8'h55;
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h1, 4'hF);
        counter_value <= 16'h1234;
        capture_input <= 4'h1;
        repeat (4) @(posedge mclk);
        chk("rise capture", capture_value[15:0], 32'h1234);
        chk("trigger", capture_trigger[0], 32'h1);
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        counter_value <= 16'h5678;
        capture_input <= 4'h0;
        repeat (4) @(posedge mclk);
        capture_input <= 4'h1;
        repeat (4) @(posedge mclk);
        chk("gated", capture_value[15:0], 32'h1234);
        bus(1'b1, `ADDR_ENABLE_POLARITY, 32'h3, 4'hF);
        counter_value <= 16'h0ABC;
        capture_input <= 4'h0;
        repeat (4) @(posedge mclk);
        chk("fall capture", capture_value[15:0], 32'h0ABC);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, `ADDR_ENABLE_POLARITY, 32'h0, 4'hF);
        chk("second reset", rd, `RESET_ENABLE_POLARITY);
        close_out();
    end
endmodule
bind timer_channel_output_control chan_out_assertions #(.DTW(DTW), .CNTW(CNTW))
    u_chan_out_assertions (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .protect_level,
    .direction_select, .compare_reference, .capture_input, .main_output,
    .main_drive_enable, .comp_output, .comp_drive_enable, .capture_trigger);
`default_nettype wire
